// ---- uls_pkg.sv ----
// Shared constants and types of the line status block
package uls_pkg;
    // Data and receive store geometry
    localparam int DW = 8;
    localparam int AW = 4;
    localparam int EW = 11;
    localparam int DEPTH = 16;
    localparam logic [4:0] FIFO_DEPTH = 5'h10;
    // Register byte offsets
    localparam logic [7:0] OFF_DATA = 8'h00;
    localparam logic [7:0] OFF_CTRL = 8'h04;
    localparam logic [7:0] OFF_DIV = 8'h08;
    localparam logic [7:0] OFF_LSR = 8'h14;
    localparam logic [7:0] OFF_IST = 8'h18;
    localparam logic [7:0] OFF_IMSK = 8'h1C;
    // Line status bit positions
    localparam int LSR_RDR = 0;
    localparam int LSR_OE = 1;
    localparam int LSR_PE = 2;
    localparam int LSR_FE = 3;
    localparam int LSR_BI = 4;
    localparam int LSR_HOLDING_EMPTY_FLAG = 5;
    localparam int LSR_TRANSMITTER_EMPTY_FLAG = 6;
    localparam int LSR_RX_FIFO_ERROR_FLAG = 7;
    // Control register bit positions
    localparam int CTRL_FEN = 0;
    localparam int CTRL_PEN = 1;
    localparam int CTRL_PODD = 2;
    // Error tags stored above each received character
    localparam int TAG_PE = 8;
    localparam int TAG_FE = 9;
    localparam int TAG_BI = 10;
    // Interrupt status bit positions
    localparam int IRQ_RX = 0;
    localparam int IRQ_OE = 1;
    localparam int IRQ_LERR = 2;
    localparam int IRQ_HOLDING_EMPTY_FLAG = 3;
    // Values after reset
    localparam logic [2:0] CTRL_RST = 3'h0;
    localparam logic [15:0] DIV_RST = 16'h0010;
    localparam logic [3:0] IMSK_RST = 4'h0;
    // Receiver states
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_START,
        ST_DATA,
        ST_PAR,
        ST_STOP,
        ST_BRKW
    } uls_rx_e;
endpackage : uls_pkg

// ---- uls_mem_if.sv ----
// Port bundle between the controller and the receive store
`timescale 1ns/1ns
interface uls_mem_if;
    logic wr_en;
    logic [uls_pkg::AW-1:0] waddr;
    logic [uls_pkg::EW-1:0] wdata;
    logic [uls_pkg::AW-1:0] raddr;
    logic [uls_pkg::EW-1:0] rdata;
    modport ctl (output wr_en, waddr, wdata, raddr, input rdata);
    modport mem (input wr_en, waddr, wdata, raddr, output rdata);
endinterface : uls_mem_if

// ---- uls_rx_mem.sv ----
// Receive character store with registered read data
`timescale 1ns/1ns
module uls_rx_mem (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Store access
    uls_mem_if.mem mif
);
    logic [uls_pkg::EW-1:0] mem [uls_pkg::DEPTH];

    // Write port
    always_ff @(posedge clk) begin
        if (mif.wr_en) begin
            mem[mif.waddr] <= mif.wdata;
        end
    end

    // Registered read port
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            mif.rdata <= '0;
        end else begin
            mif.rdata <= mem[mif.raddr];
        end
    end
endmodule : uls_rx_mem

// ---- uls_line_status.sv ----
// Line status flags of a serial receiver and transmitter, APB slave
//
// Overview of operation
// - Parity error shown in status bit 2
// - Stop bit sampled low sets framing error
// - Status read clears framing error
// - Framing error shows when character reaches head
// - Low stop bit taken as next start
// - Framing error belongs to head character
// - Whole character time low sets break
// - After break receiver idles until line high
// - Status read clears break flag
// - Break flag belongs to head character
// - Holding empty sets on empty, clears on write
// - Transmitter empty when holding and shift empty
// - Errored character loaded sets receive error flag
// - Read clears receive error only if none remain
// - Receive error flag reads zero without store
// - Wrong parity bit flags error, read clears
// - Full store: set overrun, drop new character
// - Data ready while an unread character waits
//
// Decided for this implementation: the register addresses and the APB interface to the registers.
`timescale 1ns/1ns
module uls_line_status (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Serial line
    input wire logic serial_rx_input,
    // Transmitter side
    input wire logic tx_take,
    input wire logic tx_shift_busy,
    output logic [7:0] tx_data,
    output logic tx_data_valid,
    // Interrupt
    output logic irq
);
    logic [2:0] ctrl_r;
    logic [15:0] div_r;
    logic [3:0] imsk_r;
    logic [3:0] ist_r;
    logic [31:0] prdata_r;
    logic [7:0] tx_data_r;
    logic thr_full_r;
    logic oe_r, pe_r, fe_r, bi_r, rx_fifo_error_flag_r;
    logic [3:0] wp_r, rp_r;
    logic [4:0] cnt_r;
    wire [15:0] etag_r;
    logic hn_q1_r, hn_q2_r;
    uls_pkg::uls_rx_e st_r, st_nxt;
    logic [15:0] cntb_r, cntb_nxt;
    logic [2:0] bit_r, bit_nxt;
    logic [7:0] sh_r, sh_nxt;
    logic zero_r, zero_nxt, par_r, par_nxt, peb_r, peb_nxt;
    logic rx_push, push_fe, push_bi;
    uls_mem_if mif ();

    // Bus decode
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire rd_setup = psel & ~penable & ~pwrite;
    wire sel_data = paddr == uls_pkg::OFF_DATA;
    wire sel_ctrl = paddr == uls_pkg::OFF_CTRL;
    wire sel_div = paddr == uls_pkg::OFF_DIV;
    wire sel_lsr = paddr == uls_pkg::OFF_LSR;
    wire sel_ist = paddr == uls_pkg::OFF_IST;
    wire sel_imsk = paddr == uls_pkg::OFF_IMSK;
    wire hit = sel_data | sel_ctrl | sel_div | sel_lsr | sel_ist | sel_imsk;
    wire thr_wr = wr & sel_data;
    wire ctrl_wr = wr & sel_ctrl;
    wire lsr_rd = rd & sel_lsr;
    wire fen = ctrl_r[uls_pkg::CTRL_FEN];
    assign pready = 1'b1;
    assign pslverr = acc & ~hit;
    assign prdata = prdata_r;

    // Receive store occupancy
    wire empty = cnt_r == 5'h00;
    wire full = fen ? (cnt_r == uls_pkg::FIFO_DEPTH) : !empty;
    wire do_push = rx_push & ~full;
    wire oe_evt = rx_push & full;
    wire pop = rd & sel_data & ~empty;
    wire flush = ctrl_wr & (pwdata[uls_pkg::CTRL_FEN] != fen);
    wire [3:0] tags = {1'b0, push_bi, push_fe, peb_r & ~push_bi};
    wire wr_err = |tags;
    wire hn = (pop & ((cnt_r > 5'h01) | do_push)) | (do_push & empty);
    wire [uls_pkg::EW-1:0] head = mif.rdata;
    wire head_err = |head[uls_pkg::TAG_BI:uls_pkg::TAG_PE];
    assign mif.wr_en = do_push;
    assign mif.waddr = wp_r;
    assign mif.wdata = {tags[2:0], sh_r};
    assign mif.raddr = rp_r;

    // Transmit and receive status flags
    // holding empty follows holding register
    wire holding_empty_flag = ~thr_full_r;
    wire transmitter_empty_flag = holding_empty_flag & ~tx_shift_busy;
    // data ready while store holds data
    wire rx_data_ready_flag = ~empty;
    wire rx_fifo_error_flag = rx_fifo_error_flag_r & fen;
    wire [7:0] lsr_val = {rx_fifo_error_flag, transmitter_empty_flag, holding_empty_flag, bi_r, fe_r, pe_r, oe_r, rx_data_ready_flag};
    // Read data selection
    wire [31:0] rd_val =
        sel_data ? {24'h000000, head[7:0]} :
        sel_ctrl ? {29'h00000000, ctrl_r} :
        sel_div ? {16'h0000, div_r} :
        sel_lsr ? {24'h000000, lsr_val} :
        sel_ist ? {28'h0000000, ist_r} :
        sel_imsk ? {28'h0000000, imsk_r} : 32'h00000000;
    // clear only flags the read returned
    wire [7:0] lsr_clr = lsr_rd ? prdata_r[7:0] : 8'h00;
    wire [3:0] irq_ev = {tx_take & ~thr_wr, hn_q2_r & head_err,
        oe_evt, do_push};
    wire [3:0] ist_clr = (wr & sel_ist) ? pwdata[3:0] : 4'h0;
    assign irq = |(ist_r & imsk_r);
    assign tx_data = tx_data_r;
    assign tx_data_valid = thr_full_r;

    // Bit timing
    wire tick = cntb_r == 16'h0000;
    wire rx = serial_rx_input;

    // Receiver sequencer
    always_comb begin
        st_nxt = st_r;
        cntb_nxt = tick ? div_r - 16'h0001 : cntb_r - 16'h0001;
        bit_nxt = bit_r;
        sh_nxt = sh_r;
        zero_nxt = zero_r;
        par_nxt = par_r;
        peb_nxt = peb_r;
        rx_push = 1'b0;
        push_fe = 1'b0;
        push_bi = 1'b0;
        case (st_r)
            uls_pkg::ST_IDLE: begin
                cntb_nxt = div_r >> 1;
                if (!rx) begin
                    st_nxt = uls_pkg::ST_START;
                end
            end
            uls_pkg::ST_START: begin
                if (tick) begin
                    st_nxt = rx ? uls_pkg::ST_IDLE : uls_pkg::ST_DATA;
                    bit_nxt = 3'h0;
                    zero_nxt = 1'b1;
                    par_nxt = 1'b0;
                    peb_nxt = 1'b0;
                end
            end
            uls_pkg::ST_DATA: begin
                if (tick) begin
                    sh_nxt = {rx, sh_r[7:1]};
                    zero_nxt = zero_r & ~rx;
                    par_nxt = par_r ^ rx;
                    bit_nxt = bit_r + 3'h1;
                    if (bit_r == 3'h7) begin
                        st_nxt = ctrl_r[uls_pkg::CTRL_PEN] ?
                            uls_pkg::ST_PAR : uls_pkg::ST_STOP;
                    end
                end
            end
            uls_pkg::ST_PAR: begin
                if (tick) begin
                    peb_nxt = par_r ^ rx ^ ctrl_r[uls_pkg::CTRL_PODD];
                    zero_nxt = zero_r & ~rx;
                    st_nxt = uls_pkg::ST_STOP;
                end
            end
            uls_pkg::ST_STOP: begin
                if (tick) begin
                    rx_push = 1'b1;
                    if (rx) begin
                        st_nxt = uls_pkg::ST_IDLE;
                    end else if (zero_r) begin
                        push_bi = 1'b1;
                        st_nxt = uls_pkg::ST_BRKW;
                    end else begin
                        // low stop bit is framing error
                        push_fe = 1'b1;
                        st_nxt = uls_pkg::ST_DATA;
                        bit_nxt = 3'h0;
                        zero_nxt = 1'b1;
                        par_nxt = 1'b0;
                        peb_nxt = 1'b0;
                    end
                end
            end
            uls_pkg::ST_BRKW: begin
                if (rx) begin
                    st_nxt = uls_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = uls_pkg::ST_IDLE;
            end
        endcase
    end

    // Receiver registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_r <= uls_pkg::ST_IDLE;
            cntb_r <= 16'h0000;
            bit_r <= 3'h0;
            sh_r <= 8'h00;
            zero_r <= 1'b0;
            par_r <= 1'b0;
            peb_r <= 1'b0;
        end else begin
            st_r <= st_nxt;
            cntb_r <= cntb_nxt;
            bit_r <= bit_nxt;
            sh_r <= sh_nxt;
            zero_r <= zero_nxt;
            par_r <= par_nxt;
            peb_r <= peb_nxt;
        end
    end

    // Software registers and read capture
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= uls_pkg::CTRL_RST;
            div_r <= uls_pkg::DIV_RST;
            imsk_r <= uls_pkg::IMSK_RST;
            prdata_r <= 32'h00000000;
        end else begin
            if (ctrl_wr) ctrl_r <= pwdata[2:0];
            if (wr & sel_div) div_r <= pwdata[15:0];
            if (wr & sel_imsk) imsk_r <= pwdata[3:0];
            if (rd_setup) prdata_r <= rd_val;
        end
    end

    // Holding register; a write beats a take
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            thr_full_r <= 1'b0;
            tx_data_r <= 8'h00;
        end else begin
            thr_full_r <= thr_wr | (thr_full_r & ~tx_take);
            if (thr_wr) tx_data_r <= pwdata[7:0];
        end
    end

    // Store pointers, count and head pipeline
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_r <= 4'h0;
            rp_r <= 4'h0;
            cnt_r <= 5'h00;
            hn_q1_r <= 1'b0;
            hn_q2_r <= 1'b0;
        end else begin
            if (flush) begin
                wp_r <= 4'h0;
                rp_r <= 4'h0;
                cnt_r <= 5'h00;
            end else begin
                if (do_push) wp_r <= wp_r + 4'h1;
                if (pop) rp_r <= rp_r + 4'h1;
                cnt_r <= cnt_r + {4'h0, do_push} - {4'h0, pop};
            end
            hn_q1_r <= hn & ~flush;
            hn_q2_r <= hn_q1_r;
        end
    end

    // Error tag of each stored character
    for (genvar i = 0; i < uls_pkg::DEPTH; i++) begin : g_tag
        wire set_i = do_push & wr_err & (wp_r == 4'(i));
        wire clr_i = flush | (pop & (rp_r == 4'(i)));
        logic tag_r;
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) tag_r <= 1'b0;
            else tag_r <= set_i | (tag_r & ~clr_i);
        end
        assign etag_r[i] = tag_r;
    end

    // Sticky status flags; a set beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_r <= 1'b0;
            pe_r <= 1'b0;
            fe_r <= 1'b0;
            bi_r <= 1'b0;
            rx_fifo_error_flag_r <= 1'b0;
            ist_r <= 4'h0;
        end else begin
            oe_r <= oe_evt | (oe_r & ~lsr_clr[uls_pkg::LSR_OE]);
            // parity flag from head, read clears
            pe_r <= (hn_q2_r & head[uls_pkg::TAG_PE]) |
                (pe_r & ~lsr_clr[uls_pkg::LSR_PE]);
            fe_r <= (hn_q2_r & head[uls_pkg::TAG_FE]) |
                (fe_r & ~lsr_clr[uls_pkg::LSR_FE]);
            bi_r <= (hn_q2_r & head[uls_pkg::TAG_BI]) |
                (bi_r & ~lsr_clr[uls_pkg::LSR_BI]);
            // errored load sets, clears if none left
            rx_fifo_error_flag_r <= (do_push & wr_err) | (rx_fifo_error_flag_r &
                ~(lsr_clr[uls_pkg::LSR_RX_FIFO_ERROR_FLAG] & ~|etag_r));
            ist_r <= irq_ev | (ist_r & ~ist_clr);
        end
    end

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_PE_BIT: assert property (
        lsr_rd |-> prdata[2] == $past(pe_r))
        else $error("parity flag not in status bit 2");
    AST_FE_SET: assert property (
        st_r == uls_pkg::ST_STOP && tick && !rx && !zero_r
        |-> rx_push && push_fe)
        else $error("low stop bit not reported as framing error");
    AST_FE_CLR: assert property (
        lsr_rd && prdata[3] && !hn_q2_r |=> !fe_r)
        else $error("framing flag survived status read");
    AST_FE_HEAD: assert property (
        hn_q2_r && head[uls_pkg::TAG_FE] |=> fe_r)
        else $error("framing flag missing for head character");
    AST_RESYNC: assert property (
        push_fe |=> st_r == uls_pkg::ST_DATA && bit_r == 3'h0)
        else $error("receiver did not resync on low stop");
    AST_BRK_SET: assert property (
        st_r == uls_pkg::ST_STOP && tick && !rx && zero_r
        |=> st_r == uls_pkg::ST_BRKW && $past(push_bi))
        else $error("break not detected");
    AST_BRK_IDLE: assert property (
        st_r == uls_pkg::ST_BRKW && !rx |=> st_r == uls_pkg::ST_BRKW
        && !$past(rx_push))
        else $error("receiver left break while line low");
    AST_HOLDING_EMPTY_FLAG: assert property (
        thr_wr |=> !lsr_val[uls_pkg::LSR_HOLDING_EMPTY_FLAG] ##1 tx_data == $past(pwdata[7:0], 2))
        else $error("holding empty not cleared by write");
    AST_TRANSMITTER_EMPTY_FLAG: assert property (
        tx_shift_busy || thr_full_r |-> !lsr_val[uls_pkg::LSR_TRANSMITTER_EMPTY_FLAG])
        else $error("transmitter empty while data held");
    AST_RX_FIFO_ERROR_FLAG_HOLD: assert property (
        lsr_rd && rx_fifo_error_flag_r && |etag_r |=> rx_fifo_error_flag_r)
        else $error("receive error flag cleared with errors left");
    AST_RX_FIFO_ERROR_FLAG_OFF: assert property (
        !fen |-> !lsr_val[uls_pkg::LSR_RX_FIFO_ERROR_FLAG])
        else $error("receive error flag set without store");
    AST_OVR: assert property (
        oe_evt && !pop && !flush |=> oe_r && cnt_r == $past(cnt_r))
        else $error("overrun not handled");
    AST_RDR: assert property (
        lsr_val[uls_pkg::LSR_RDR] == (cnt_r != 5'h00))
        else $error("data ready disagrees with occupancy");

    // Receive store
    uls_rx_mem u_mem (
        .clk(pclk),
        .rst_n(presetn),
        .mif(mif)
    );
endmodule : uls_line_status

// ---- uls_serial_tx_model.sv ----
// Remote serial transmitter driving the receive line
`timescale 1ns/1ns
module uls_serial_tx_model #(
    parameter int BIT_CYCLES = 16
) (
    // Clock
    input wire logic pclk,
    // Serial line toward the receiver, idles high
    output logic line
);
    initial line = 1'b1;

    // One bit level held for one bit period
    task automatic put_bit(input logic b);
        line <= b;
        repeat (BIT_CYCLES) @(posedge pclk);
    endtask : put_bit

    // One frame, LSB first, optional parity, chosen stop level
    task automatic send(input logic [7:0] d, input logic has_par,
                        input logic par, input logic stop);
        @(posedge pclk);
        put_bit(1'b0);
        for (int i = 0; i < 8; i++) begin
            put_bit(d[i]);
        end
        if (has_par) begin
            put_bit(par);
        end
        put_bit(stop);
        put_bit(1'b1);
    endtask : send

    // spacing state for whole bit periods
    task automatic hold_low(input int bits);
        @(posedge pclk);
        line <= 1'b0;
        repeat (bits * BIT_CYCLES) @(posedge pclk);
        line <= 1'b1;
        repeat (2 * BIT_CYCLES) @(posedge pclk);
    endtask : hold_low
endmodule : uls_serial_tx_model

// ---- test_uls_line_status.sv ----
// Self-checking testbench of the line status block
`timescale 1ns/1ns
module test_uls_line_status;
    localparam logic [7:0] A_ST = uls_pkg::OFF_LSR;
    localparam logic [7:0] A_DT = uls_pkg::OFF_DATA;
    localparam logic [7:0] A_CT = uls_pkg::OFF_CTRL;
    localparam logic [7:0] A_IS = uls_pkg::OFF_IST;
    localparam logic [7:0] A_IM = uls_pkg::OFF_IMSK;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rv;
    logic serial_rx_input, tx_take, tx_shift_busy, tx_data_valid, irq, ev;
    logic [7:0] tx_data, d, g;
    logic odd;
    int n_mismatch = 0;
    int check_count = 0;
    int seed_v;

    // Clock, 8 ns period
    initial pclk = 1'b0;
    always #4 pclk = ~pclk;

    uls_line_status i_uls_line_status (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .serial_rx_input(serial_rx_input),
        .tx_take(tx_take), .tx_shift_busy(tx_shift_busy),
        .tx_data(tx_data), .tx_data_valid(tx_data_valid), .irq(irq));
    uls_serial_tx_model i_uls_serial_tx_model (.pclk(pclk),
        .line(serial_rx_input));

    // Compare and count
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("Error at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // Verdict and end of run
    task automatic test_done;
        $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done

    // One APB transfer, read data and error kept in rv and ev
    task automatic apb(input logic wr, input logic [7:0] a,
                       input logic [31:0] wd);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            n++;
            @(posedge pclk);
        end
        if (n >= 50) begin
            chk(32'h0, 32'h1);
        end
        rv = prdata;
        ev = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic wr(input logic [7:0] a, input logic [31:0] wd);
        apb(1'b1, a, wd);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        apb(1'b0, a, 32'h0);
    endtask : rd

    // Parity bit that a correct sender puts on the line
    function automatic logic par_of(input logic [7:0] v, input logic o);
        return (^v) ^ o;
    endfunction : par_of

    // Read the status and compare the bits under a mask
    task automatic st_is(input logic [7:0] m, input logic [7:0] e);
        rd(A_ST);
        chk(rv & {24'h0, m}, {24'h0, e});
    endtask : st_is

    // Watchdog
    initial begin
        repeat (60000) @(posedge pclk);
        n_mismatch++;
        $display("Error at %0t: run did not finish", $time);
        test_done();
    end

    // Main sequence
    initial begin
        presetn = 1'b0;
        {psel, penable, pwrite, tx_take, tx_shift_busy} = 5'h00;
        paddr = 8'h00;
        pwdata = 32'h0;
        seed_v = $urandom(32'h6556);
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset values and an unmapped place
        st_is(8'hFF, 8'h60);
        rd(A_CT);
        chk(rv, 32'h0);
        rd(uls_pkg::OFF_DIV);
        chk(rv, 32'h10);
        rd(8'h30);
        chk({31'h0, ev}, 32'h1);
        // Holding and shift occupancy
        wr(A_DT, 32'hA5);
        @(posedge pclk);
        chk({24'h0, tx_data}, 32'hA5);
        chk({31'h0, tx_data_valid}, 32'h1);
        st_is(8'h60, 8'h00);
        @(posedge pclk);
        tx_take <= 1'b1;
        tx_shift_busy <= 1'b1;
        @(posedge pclk);
        tx_take <= 1'b0;
        @(posedge pclk);
        chk({31'h0, tx_data_valid}, 32'h0);
        st_is(8'h60, 8'h20);
        tx_shift_busy <= 1'b0;
        st_is(8'h60, 8'h60);
        // Interrupt raised, masked, cleared
        rd(A_IS);
        chk(rv & 32'h8, 32'h8);
        chk({31'h0, irq}, 32'h0);
        wr(A_IM, 32'h8);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        wr(A_IS, 32'hF);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        // Random clean characters through the store
        repeat (6) begin
            d = 8'($urandom);
            odd = 1'($urandom);
            wr(A_CT, {29'h0, odd, 2'h3});
            i_uls_serial_tx_model.send(d, 1'b1, par_of(d, odd), 1'b1);
            repeat (4) @(posedge pclk);
            st_is(8'h9D, 8'h01);
            rd(A_DT);
            chk(rv, {24'h0, d});
            st_is(8'h01, 8'h00);
        end
        // Flags follow the head character
        wr(A_CT, 32'h7);
        g = 8'($urandom);
        d = 8'($urandom);
        i_uls_serial_tx_model.send(g, 1'b1, par_of(g, 1'b1), 1'b1);
        i_uls_serial_tx_model.send(d, 1'b1, ~par_of(d, 1'b1), 1'b1);
        i_uls_serial_tx_model.send(d, 1'b1, ~par_of(d, 1'b1), 1'b1);
        repeat (4) @(posedge pclk);
        st_is(8'h9D, 8'h81);
        st_is(8'h9D, 8'h81);
        rd(A_DT);
        repeat (4) @(posedge pclk);
        st_is(8'h9D, 8'h85);
        st_is(8'h9D, 8'h81);
        rd(A_DT);
        chk(rv, {24'h0, d});
        repeat (4) @(posedge pclk);
        st_is(8'h9D, 8'h85);
        rd(A_DT);
        repeat (4) @(posedge pclk);
        st_is(8'h9D, 8'h80);
        st_is(8'h9D, 8'h00);
        // Low stop bit, then resync to a second character
        wr(A_CT, 32'h1);
        i_uls_serial_tx_model.send(g, 1'b0, 1'b0, 1'b0);
        repeat (12 * 16) @(posedge pclk);
        st_is(8'h9D, 8'h89);
        st_is(8'h9D, 8'h81);
        rd(A_DT);
        chk(rv, {24'h0, g});
        rd(A_DT);
        chk(rv, 32'hFF);
        st_is(8'h01, 8'h00);
        st_is(8'h9D, 8'h00);
        // Line held low past a whole character
        i_uls_serial_tx_model.hold_low(12);
        st_is(8'h95, 8'h91);
        st_is(8'h95, 8'h81);
        rd(A_DT);
        chk(rv, 32'h0);
        repeat (4) @(posedge pclk);
        st_is(8'h01, 8'h00);
        // Depth one: overrun, parity error, no store error
        wr(A_CT, 32'h2);
        wr(A_IM, 32'h1);
        i_uls_serial_tx_model.send(d, 1'b1, ~par_of(d, 1'b0), 1'b1);
        i_uls_serial_tx_model.send(g, 1'b1, par_of(g, 1'b0), 1'b1);
        repeat (4) @(posedge pclk);
        chk({31'h0, irq}, 32'h1);
        st_is(8'h87, 8'h07);
        rd(A_DT);
        chk(rv, {24'h0, d});
        wr(A_IS, 32'hF);
        @(posedge pclk);
        chk({31'h0, irq}, 32'h0);
        st_is(8'h03, 8'h00);
        test_done();
    end
endmodule : test_uls_line_status
